// ==== rtl/lsl_defines.svh ====
// timing counts, widths and reset values for the serdes lane
`ifndef LSL_DEFINES_SVH
`define LSL_DEFINES_SVH
`define LSL_MAX_WIDTH 10
`define LSL_CNT_W 4
`define LSL_TAP_W 6
`define LSL_TAP_MID 6'h20
`define LSL_TAP_MAX 6'h3f
`define LSL_QUEUE_DEPTH 8
`define LSL_LOCK_HITS 4'h8
`define LSL_TERM_OHMS 100
`endif

// ==== rtl/lsl_pkg.sv ====
// types for the serdes lane
package lsl_pkg;
	typedef enum logic [2:0] {
		LSL_TRAIN_IDLE = 3'b001,
		LSL_TRAIN_SEEK = 3'b010,
		LSL_TRAIN_LOCK = 3'b100
	} lsl_train_t;
	typedef enum logic [1:0] {
		LSL_RATE_FULL = 2'b01,
		LSL_RATE_HALF = 2'b10
	} lsl_rate_t;
endpackage : lsl_pkg

// ==== rtl/lsl_skid.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module lsl_skid #(
	parameter int WIDTH = 10
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] s_data_in,
	input wire logic s_valid_in,
	output logic s_ready_out,
	output logic [WIDTH-1:0] m_data_out,
	output logic m_valid_out,
	input wire logic m_ready_in
);
	logic [WIDTH-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign push = s_valid_in && s_ready_out;
	assign pop = m_valid_out && m_ready_in;
	assign m_data_out = mem[rd_ptr];

	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem[wr_ptr] <= s_data_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			s_ready_out <= 1'b1;
			m_valid_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + 2'(push) - 2'(pop);
			s_ready_out <= (count + 2'(push) - 2'(pop)) != 2'h2;
			m_valid_out <= (count + 2'(push) - 2'(pop)) != 2'h0;
		end
	end
endmodule : lsl_skid

// ==== rtl/lsl_lane.sv ====
// LVDS serdes lane: receive deserialiser with phase alignment and queue, transmit serialiser
// Function
// - full rate: bit clock equals bit rate, one bit per rising edge
// - half rate: bit clock is half bit rate, bits on both edges
// - word width programmable up to ten bits
// - complete aligned received word presented on word clock rising edge
// - width one bypass routes pad to alternate clock output
// - training-done output asserted once automatic alignment locks
// - automatic alignment steers delay tap to the bit centre
// - optional eight-entry receive queue toward core clock; none on transmit
// - queue empty flag high whenever the queue holds no words
// - receive reset asynchronous, clears queue and deserialiser
// - input buffer on while enable is 1, off while 0
// - dynamic termination connected while control is 1
// - tap-adjust enable acts on manual delay or automatic alignment
// - while adjusting, step input moves tap up on 1, down on 0
// - tap clear resets tap counter or alignment circuit
// - core presents transmit word on the word clock
// - transmit reset returns serialiser to initial state
// - output enable controls whether the pad pair is driven
// - transmit modes: serial data or reference clock
//
// One clock models the bit clock; the word clock is a one-cycle word strobe every width bits.
// Half rate carries two bits per cycle on rx_pad_pair_in / tx_pad_pair_out.
`timescale 1ns/1ps
`include "lsl_defines.svh"
module lsl_lane
	import lsl_pkg::*;
#(
	parameter int WIDTH = `LSL_MAX_WIDTH,
	parameter bit HALF_RATE = 1'b0,
	parameter bit QUEUE_ON = 1'b1,
	parameter bit AUTO_ALIGN = 1'b1,
	parameter bit DYN_TERM = 1'b1
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic tx_rst_n_in,
	input wire logic [3:0] word_width_in,
	input wire logic bypass_in,
	input wire logic [1:0] rx_pad_pair_in,
	input wire logic input_buffer_on_in,
	input wire logic term_on_in,
	input wire logic tap_adjust_on_in,
	input wire logic tap_step_up_in,
	input wire logic tap_counter_clear_in,
	input wire logic queue_read_in,
	input wire logic [WIDTH-1:0] tx_word_in,
	input wire logic tx_word_valid_in,
	input wire logic tx_oe_in,
	input wire logic ref_clock_mode_in,
	output logic [WIDTH-1:0] rx_word_out,
	output logic rx_word_valid_out,
	output logic bypass_route_output_out,
	output logic training_done_out,
	output logic queue_empty_out,
	output logic buffer_powered_out,
	output logic term_connected_out,
	output logic [`LSL_TAP_W-1:0] tap_out,
	output logic tx_word_ready_out,
	output logic [1:0] tx_pad_pair_out,
	output logic tx_pad_oe_n_out
);
	localparam int STEP = HALF_RATE ? 2 : 1;
	localparam int QW = $clog2(`LSL_QUEUE_DEPTH);

	////////////////////////////////////////////////////////////////
	// shared helpers

	function automatic logic [3:0] clamp_width(input logic [3:0] w);
		if (w == 4'h0) begin
			return 4'h1;
		end else if (w > 4'(WIDTH)) begin
			return 4'(WIDTH);
		end
		return w;
	endfunction : clamp_width

	logic [3:0] width_eff;
	assign width_eff = clamp_width(word_width_in);

	////////////////////////////////////////////////////////////////
	// pad controls

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buffer_powered_out <= 1'b0;
			term_connected_out <= 1'b0;
		end else begin
			buffer_powered_out <= input_buffer_on_in;
			term_connected_out <= DYN_TERM && term_on_in;
		end
	end

	logic [1:0] rx_bits;
	assign rx_bits = input_buffer_on_in ? rx_pad_pair_in : 2'h0;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bypass_route_output_out <= 1'b0;
		end else begin
			bypass_route_output_out <= bypass_in && width_eff == 4'h1 && rx_bits[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// deserialiser

	logic [WIDTH-1:0] rx_shift;
	logic [3:0] rx_cnt;
	logic rx_word_strobe;
	logic [WIDTH-1:0] rx_word_raw;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_shift <= '0;
			rx_cnt <= 4'h0;
			rx_word_strobe <= 1'b0;
			rx_word_raw <= '0;
		end else begin
			rx_word_strobe <= 1'b0;
			// first line bit lands at index 0
			for (int i = 0; i < STEP; i++) begin
				rx_shift[4'(rx_cnt + 4'(i))] <= rx_bits[i];
			end
			if (rx_cnt + 4'(STEP) >= width_eff) begin
				rx_cnt <= 4'h0;
				rx_word_strobe <= !bypass_in;
				rx_word_raw <= rx_shift;
				for (int i = 0; i < STEP; i++) begin
					rx_word_raw[4'(rx_cnt + 4'(i))] <= rx_bits[i];
				end
			end else begin
				rx_cnt <= rx_cnt + 4'(STEP);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// delay taps and automatic phase alignment

	lsl_train_t train_state;
	logic [`LSL_TAP_W-1:0] tap;
	logic [`LSL_TAP_W-1:0] lo_edge;
	logic [3:0] hits;
	logic prev_bit;
	logic edge_seen;
	assign edge_seen = rx_word_strobe && (rx_word_raw[0] != prev_bit);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_bit <= 1'b0;
		end else if (rx_word_strobe) begin
			prev_bit <= rx_word_raw[0];
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tap <= `LSL_TAP_MID;
			train_state <= LSL_TRAIN_IDLE;
			lo_edge <= '0;
			hits <= 4'h0;
		end else if (tap_counter_clear_in) begin
			tap <= `LSL_TAP_MID;
			train_state <= LSL_TRAIN_IDLE;
			hits <= 4'h0;
		end else if (!AUTO_ALIGN) begin
			if (tap_adjust_on_in) begin
				if (tap_step_up_in && tap != `LSL_TAP_MAX) begin
					tap <= tap + 1'b1;
				end else if (!tap_step_up_in && tap != '0) begin
					tap <= tap - 1'b1;
				end
			end
		end else if (tap_adjust_on_in && rx_word_strobe) begin
			unique case (train_state)
				LSL_TRAIN_IDLE: begin
					tap <= '0;
					lo_edge <= '0;
					train_state <= LSL_TRAIN_SEEK;
				end
				LSL_TRAIN_SEEK: begin
					// sweep; centre between the last transition and the sweep end
					if (edge_seen) begin
						lo_edge <= tap;
					end
					if (tap == `LSL_TAP_MAX) begin
						tap <= `LSL_TAP_W'(((`LSL_TAP_W+1)'(lo_edge) + `LSL_TAP_MAX) >> 1);
						train_state <= LSL_TRAIN_LOCK;
						hits <= 4'h0;
					end else begin
						tap <= tap + 1'b1;
					end
				end
				LSL_TRAIN_LOCK: begin
					if (edge_seen) begin
						hits <= 4'h0;
					end else if (hits != `LSL_LOCK_HITS) begin
						hits <= hits + 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			training_done_out <= 1'b0;
			tap_out <= `LSL_TAP_MID;
		end else begin
			training_done_out <= AUTO_ALIGN && train_state == LSL_TRAIN_LOCK
				&& hits == `LSL_LOCK_HITS;
			tap_out <= tap;
		end
	end

	////////////////////////////////////////////////////////////////
	// receive queue and output buffer

	logic [WIDTH-1:0] q_mem [`LSL_QUEUE_DEPTH];
	logic [QW:0] q_wr;
	logic [QW:0] q_rd;
	logic q_empty;
	logic q_full;
	logic q_push;
	logic q_pop;
	logic skid_ready;
	logic skid_valid;
	logic [WIDTH-1:0] skid_data;
	logic [WIDTH-1:0] src_data;
	logic src_valid;

	assign q_empty = q_wr == q_rd;
	assign q_full = (q_wr[QW] != q_rd[QW]) && (q_wr[QW-1:0] == q_rd[QW-1:0]);
	assign q_push = QUEUE_ON && rx_word_strobe && !q_full;
	assign q_pop = QUEUE_ON && queue_read_in && !q_empty && skid_ready;
	assign src_data = QUEUE_ON ? q_mem[q_rd[QW-1:0]] : rx_word_raw;
	assign src_valid = QUEUE_ON ? q_pop : rx_word_strobe;

	always_ff @(posedge mclk_in) begin
		if (q_push) begin
			q_mem[q_wr[QW-1:0]] <= rx_word_raw;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q_wr <= '0;
			q_rd <= '0;
			queue_empty_out <= 1'b1;
		end else begin
			if (q_push) begin
				q_wr <= q_wr + 1'b1;
			end
			if (q_pop) begin
				q_rd <= q_rd + 1'b1;
			end
			queue_empty_out <= (q_wr + (QW+1)'(q_push)) == (q_rd + (QW+1)'(q_pop));
		end
	end

	lsl_skid #(
		.WIDTH(WIDTH)
	) u_skid (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.s_data_in(src_data),
		.s_valid_in(src_valid),
		.s_ready_out(skid_ready),
		.m_data_out(skid_data),
		.m_valid_out(skid_valid),
		.m_ready_in(1'b1)
	);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_word_out <= '0;
			rx_word_valid_out <= 1'b0;
		end else begin
			rx_word_valid_out <= skid_valid;
			if (skid_valid) begin
				rx_word_out <= skid_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// serialiser

	logic [WIDTH-1:0] tx_shift;
	logic [3:0] tx_cnt;
	logic tx_load;
	assign tx_load = tx_cnt + 4'(STEP) >= width_eff;

	always_ff @(posedge mclk_in or negedge tx_rst_n_in) begin
		if (!tx_rst_n_in) begin
			tx_shift <= '0;
			tx_cnt <= 4'h0;
			tx_word_ready_out <= 1'b0;
			tx_pad_pair_out <= 2'h0;
			tx_pad_oe_n_out <= 1'b1;
		end else begin
			tx_word_ready_out <= tx_load;
			tx_pad_oe_n_out <= !tx_oe_in;
			tx_cnt <= tx_load ? 4'h0 : tx_cnt + 4'(STEP);
			if (tx_load) begin
				tx_shift <= tx_word_valid_in ? tx_word_in : '0;
			end
			if (ref_clock_mode_in) begin
				// ref clock: high while tx_cnt is below half of width_eff (first half of the word at full rate)
				tx_pad_pair_out <= {2{tx_cnt < (width_eff >> 1)}};
			end else begin
				for (int i = 0; i < 2; i++) begin
					tx_pad_pair_out[i] <= (i < STEP) ? tx_shift[4'(tx_cnt + 4'(i))] : 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	property p_empty_seen;
		@(posedge mclk_in) disable iff (!rst_n_in)
		q_empty |=> queue_empty_out || $past(q_push);
	endproperty
	a_empty_seen: assert property (p_empty_seen) else $error("empty flag low");
	property p_empty_flag;
		@(posedge mclk_in) disable iff (!rst_n_in) queue_empty_out |-> q_empty;
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag with data");
	property p_done;
		@(posedge mclk_in) disable iff (!rst_n_in)
		training_done_out && !$past(tap_counter_clear_in)
		|-> AUTO_ALIGN && train_state == LSL_TRAIN_LOCK;
	endproperty
	a_done: assert property (p_done) else $error("done without lock");
	property p_tap_up;
		@(posedge mclk_in) disable iff (!rst_n_in)
		!AUTO_ALIGN && tap_adjust_on_in && tap_step_up_in && !tap_counter_clear_in
		&& tap != `LSL_TAP_MAX |=> tap == $past(tap) + 1'b1;
	endproperty
	a_tap_up: assert property (p_tap_up) else $error("tap up");
	sequence s_tap_mid;
		tap == `LSL_TAP_MID ##1 tap_out == `LSL_TAP_MID;
	endsequence
	property p_clear;
		@(posedge mclk_in) disable iff (!rst_n_in) tap_counter_clear_in |=> s_tap_mid;
	endproperty
	a_clear: assert property (p_clear) else $error("tap clear");
	property p_buf;
		@(posedge mclk_in) disable iff (!rst_n_in) input_buffer_on_in |=> buffer_powered_out;
	endproperty
	a_buf: assert property (p_buf) else $error("buffer on");
	property p_term;
		@(posedge mclk_in) disable iff (!rst_n_in)
		DYN_TERM && !term_on_in |=> !term_connected_out;
	endproperty
	a_term: assert property (p_term) else $error("term off");
	property p_oe;
		@(posedge mclk_in) disable iff (!tx_rst_n_in) tx_oe_in |=> !tx_pad_oe_n_out;
	endproperty
	a_oe: assert property (p_oe) else $error("pad oe");
endmodule : lsl_lane

// ==== bench/lsl_far_end.sv ====
// far-end lvds transmitter and receiver models facing the lane pads
`timescale 1ns/1ps
module lsl_far_end (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic hold_in,
	input wire logic lvl_in,
	input wire logic [1:0] tx_pad_pair_in,
	output logic [1:0] rx_pad_pair_out
);
	logic [9:0] sent[$];
	logic [9:0] got[$];
	logic [9:0] w;
	logic [9:0] sh;
	int b;
	int nr;
	bit sync;
	//////////////////////////////
	// first word is on the pad at the first edge after reset, so both sides count alike
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			b <= 0;
			w <= 10'h2b5;
			sent.delete();
			sent.push_back(10'h2b5);
		end else if (b == 9) begin
			b <= 0;
			w <= w * 10'h0d + 10'h3b;
			sent.push_back(w * 10'h0d + 10'h3b);
		end else begin
			b <= b + 1;
		end
	end
	// lvds never floats, so hold forces a level for the bypass check
	assign rx_pad_pair_out = hold_in ? {~lvl_in, lvl_in} : {~w[b], w[b]};
	//////////////////////////////
	// word boundary found from the first set bit; the lane idles low after reset
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sync = 1'b0;
			nr = 0;
		end else if (sync || tx_pad_pair_in[0]) begin
			sync = 1'b1;
			sh = {tx_pad_pair_in[0], sh[9:1]};
			nr = nr + 1;
			if (nr == 10) begin
				nr = 0;
				got.push_back(sh);
			end
		end
	end
endmodule : lsl_far_end

// ==== bench/lsl_lane_tb.sv ====
// self-checking bench for the lvds serdes lane
`timescale 1ns/1ps
module lsl_lane_tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic tx_rst_n_in = 1'b0;
	logic [3:0] word_width_in = 4'ha;
	logic bypass_in = 1'b0;
	logic [1:0] rx_pad_pair_in;
	logic input_buffer_on_in = 1'b1;
	logic term_on_in = 1'b1;
	logic tap_adjust_on_in = 1'b0;
	logic tap_step_up_in = 1'b0;
	logic tap_counter_clear_in = 1'b0;
	logic queue_read_in = 1'b0;
	logic [9:0] tx_word_in = 10'h2a1;
	logic tx_word_valid_in = 1'b1;
	logic tx_oe_in = 1'b1;
	logic ref_clock_mode_in = 1'b0;
	logic [9:0] rx_word_out;
	logic rx_word_valid_out, bypass_route_output_out, training_done_out, queue_empty_out;
	logic buffer_powered_out, term_connected_out, tx_word_ready_out, tx_pad_oe_n_out;
	logic [5:0] tap_out;
	logic [1:0] tx_pad_pair_out;
	logic al_done;
	logic [5:0] al_tap;
	logic hold = 1'b0, lvl = 1'b0, rd_on = 1'b0, chk_rx = 1'b1, pv = 1'b0;
	logic [31:0] rng = 32'h04c0;
	logic [9:0] txq[$];
	int mismatches = 0, n_checks = 0, tog;

	lsl_lane #(.AUTO_ALIGN(1'b0))
	dut_u (.mclk_in, .rst_n_in, .tx_rst_n_in, .word_width_in, .bypass_in, .rx_pad_pair_in,
		.input_buffer_on_in, .term_on_in, .tap_adjust_on_in, .tap_step_up_in,
		.tap_counter_clear_in, .queue_read_in, .tx_word_in, .tx_word_valid_in, .tx_oe_in,
		.ref_clock_mode_in, .rx_word_out, .rx_word_valid_out, .bypass_route_output_out,
		.training_done_out, .queue_empty_out, .buffer_powered_out, .term_connected_out,
		.tap_out, .tx_word_ready_out, .tx_pad_pair_out, .tx_pad_oe_n_out);
	// second lane with automatic alignment; a steady pad level gives it no edges to chase
	lsl_lane dut_a (.mclk_in, .rst_n_in, .tx_rst_n_in, .word_width_in, .bypass_in,
		.rx_pad_pair_in({~lvl, lvl}), .input_buffer_on_in, .term_on_in, .tap_adjust_on_in,
		.tap_step_up_in(1'b0), .tap_counter_clear_in, .queue_read_in, .tx_word_in,
		.tx_word_valid_in, .tx_oe_in, .ref_clock_mode_in, .rx_word_out(), .rx_word_valid_out(),
		.bypass_route_output_out(), .training_done_out(al_done), .queue_empty_out(),
		.buffer_powered_out(), .term_connected_out(), .tap_out(al_tap), .tx_word_ready_out(),
		.tx_pad_pair_out(), .tx_pad_oe_n_out());
	lsl_far_end far_u (.mclk_in, .rst_n_in, .hold_in(hold), .lvl_in(lvl),
		.tx_pad_pair_in(tx_pad_pair_out), .rx_pad_pair_out(rx_pad_pair_in));

	always #2.5 mclk_in = ~mclk_in;
	//////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// reads at three in four cycles outpace one word per ten, so the queue never drops
	task automatic run(input int n);
		repeat (n) begin
			@(negedge mclk_in);
			rng = xs(rng);
			queue_read_in = rd_on && (rng[1:0] != 2'b00);
			if (tx_word_ready_out === 1'b1) begin
				txq.push_back(tx_word_valid_in ? tx_word_in : 10'h0);
				tx_word_in = rng[13:4];
				tx_word_valid_in = rng[14];
			end
		end
	endtask : run

	always @(negedge mclk_in) begin
		if (chk_rx && rx_word_valid_out === 1'b1) begin
			check("rx_word", rx_word_out, far_u.sent.pop_front());
		end
	end
	//////////////////////////////
	initial begin
		repeat (16) @(negedge mclk_in);
		rst_n_in = 1'b1;
		tx_rst_n_in = 1'b1;
		@(negedge mclk_in);
		check("empty", 10'(queue_empty_out), 10'h1);
		check("tap", 10'(tap_out), 10'h20);
		rd_on = 1'b1;
		run(600);
		tap_adjust_on_in = 1'b1;
		tap_step_up_in = 1'b1;
		run(700);
		check("tap", 10'(tap_out), 10'h3f);
		tap_counter_clear_in = 1'b1;
		run(20);
		check("tap", 10'(tap_out), 10'h20);
		check("align_clear", {3'h0, al_done, al_tap}, 10'h020);
		tap_counter_clear_in = 1'b0;
		tap_step_up_in = 1'b0;
		run(800);
		check("tap", 10'(tap_out), 10'h00);
		check("align_done", 10'(al_done), 10'h1);
		check("align_tap", 10'(al_tap), 10'h1f);
		tap_adjust_on_in = 1'b0;
		rd_on = 1'b0;
		run(40);
		check("empty", 10'(queue_empty_out), 10'h0);
		rd_on = 1'b1;
		run(100);
		chk_rx = 1'b0;
		check("tx_count", 10'(far_u.got.size() > 100), 10'h1);
		while (far_u.got.size() > 0 && txq.size() > 0) begin
			check("tx_word", far_u.got.pop_front(), txq.pop_front());
		end
		tx_rst_n_in = 1'b0;
		@(negedge mclk_in);
		check("tx_reset", {7'h0, tx_pad_oe_n_out, tx_pad_pair_out}, 10'h004);
		tx_rst_n_in = 1'b1;
		term_on_in = 1'b0;
		input_buffer_on_in = 1'b0;
		tx_oe_in = 1'b0;
		run(3);
		check("term", 10'(term_connected_out), 10'h0);
		check("buf", 10'(buffer_powered_out), 10'h0);
		check("oe_n", 10'(tx_pad_oe_n_out), 10'h1);
		term_on_in = 1'b1;
		input_buffer_on_in = 1'b1;
		tx_oe_in = 1'b1;
		ref_clock_mode_in = 1'b1;
		run(3);
		check("term", 10'(term_connected_out), 10'h1);
		check("buf", 10'(buffer_powered_out), 10'h1);
		check("oe_n", 10'(tx_pad_oe_n_out), 10'h0);
		tog = 0;
		repeat (40) begin
			@(negedge mclk_in);
			if (tx_pad_pair_out[0] !== pv) tog++;
			pv = tx_pad_pair_out[0];
		end
		check("ref_clock", 10'(tog >= 4), 10'h1);
		word_width_in = 4'h1;
		bypass_in = 1'b1;
		hold = 1'b1;
		lvl = 1'b1;
		run(4);
		check("bypass", 10'(bypass_route_output_out), 10'h1);
		lvl = 1'b0;
		run(4);
		check("bypass", 10'(bypass_route_output_out), 10'h0);
		wrap_up();
	end

	// about 1.7 times the expected run length of some 2332 cycles
	initial begin
		#20000;
		mismatches++;
		wrap_up();
	end
endmodule : lsl_lane_tb
